// file: hdl/eac_pkg.sv
// Constants shared by the data EEPROM access controller.
// Function
// (RULE_01) Unused address and control bits read zero.
// (RULE_02) Nine-bit linear byte address, 512 locations.
// (RULE_03) Software loads an address before access.
// (RULE_04) Data register sources writes, receives reads.
// (RULE_05) Ready interrupt while enabled and strobe clear.
// (RULE_06) Write starts only with strobe inside arm window.
// (RULE_07) Arm bit self-clears after four cycles.
// (RULE_08) Software follows the documented write sequence.
// (RULE_09) No write while flash self-programming runs.
// (RULE_10) Software keeps interrupts off during writes.
// (RULE_11) Write strobe stays set until write completes.
// (RULE_12) Write start stalls the CPU two cycles.
// (RULE_13) Read strobe fetches byte into data register.
// (RULE_14) Read stalls the CPU four cycles.
// (RULE_15) Busy write blocks reads and address changes.
// (RULE_16) Write lasts 8448 one-megahertz oscillator cycles.
// (RULE_17) Running write survives a non-power reset.
// (RULE_18) Strobe ignored while a write runs.
package eac_pkg;
	// Register offsets in the I/O window.
	localparam logic [1:0] OFS_ADDR_HIGH = 2'h0;
	localparam logic [1:0] OFS_ADDR_LOW  = 2'h1;
	localparam logic [1:0] OFS_DATA      = 2'h2;
	localparam logic [1:0] OFS_CONTROL   = 2'h3;
	// Control register bit positions.
	localparam int BIT_READY_IE = 3;
	localparam int BIT_ARM      = 2;
	localparam int BIT_WSTROBE  = 1;
	localparam int BIT_RSTROBE  = 0;
	// Values after reset.
	localparam logic [8:0] ADDR_RESET = 9'h000;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// Timing.
	localparam int ARM_CYCLES       = 4;
	localparam int WRITE_STALL      = 2;
	localparam int READ_STALL       = 4;
	localparam int CLK_HZ           = 100_000_000;
	localparam int OSC_HZ           = 1_000_000;
	localparam int WRITE_OSC_CYCLES = 8448;
	localparam int WRITE_CLKS       = WRITE_OSC_CYCLES * (CLK_HZ / OSC_HZ);
endpackage

// file: hdl/eac_ctrl.sv
// Data EEPROM access controller: address, data and control registers with write timing.
`timescale 1ns/1ps
module eac_ctrl
	import eac_pkg::*;
#(
	parameter int WRITE_TIME_CLKS = WRITE_CLKS
)
(
	// Clock and resets.
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       pwr_resetn,
	// I/O space register port.
	input  wire logic [1:0] io_addr,
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [7:0] io_wdata,
	output logic      [7:0] io_rdata,
	// Core status.
	input  wire logic       core_irq_enable,
	input  wire logic       self_program_active,
	output logic            cpu_stall,
	output logic            rom_ready_irq,
	// EEPROM cell array.
	output logic      [8:0] mem_addr,
	output logic      [7:0] mem_wdata,
	output logic            mem_we,
	output logic            mem_re,
	input  wire logic [7:0] mem_rdata
);
	// Refuse a write time that the 20-bit write timer cannot hold.
	if (WRITE_TIME_CLKS < 1 || WRITE_TIME_CLKS > 1048575)
	begin : g_bad_write_time
		$error("WRITE_TIME_CLKS out of range");
	end

	// Registered state and decoded strobes.
	logic [8:0]  rom_addr_ff,   nxt_rom_addr;
	logic [7:0]  rom_data_ff,   nxt_rom_data;
	logic [7:0]  rdata_ff,      nxt_rdata;
	logic        ready_ie_ff,   nxt_ready_ie;
	logic        arm_ff,        nxt_arm;
	logic [2:0]  arm_cnt_ff,    nxt_arm_cnt;
	logic        busy_ff,       nxt_busy;
	logic [19:0] wcnt_ff,       nxt_wcnt;
	logic        we_ff,         nxt_we;
	logic        re_ff,         nxt_re;
	logic        cap_ff,        nxt_cap;
	logic [2:0]  stall_ff,      nxt_stall;
	logic        wr_ctrl;
	logic        start_write;
	logic        start_read;

	// Decode of a control register write.
	assign wr_ctrl     = io_wr && io_addr == OFS_CONTROL;
	// A write strobe only counts inside the arm window, outside a write and outside flash programming.
	// A plain reset refuses new strobes but leaves a running write alone.
	assign start_write = resetn && wr_ctrl && io_wdata[BIT_WSTROBE] && arm_ff && !busy_ff // see RULE_06 see RULE_18
		&& !self_program_active;                                                 // see RULE_09
	assign start_read  = wr_ctrl && io_wdata[BIT_RSTROBE] && !busy_ff && !start_write; // see RULE_15

	// Next-state logic for registers, timers and strobes.
	always_comb
	begin
		nxt_rom_addr = rom_addr_ff;
		nxt_rom_data = rom_data_ff;
		nxt_ready_ie = ready_ie_ff;
		nxt_arm      = arm_ff;
		nxt_arm_cnt  = arm_cnt_ff;
		nxt_busy     = busy_ff;
		nxt_wcnt     = wcnt_ff;
		nxt_we       = start_write;
		nxt_re       = start_read;
		nxt_cap      = re_ff;
		nxt_stall    = (stall_ff != 3'h0) ? stall_ff - 3'h1 : 3'h0;
		nxt_rdata    = 8'h00;
		// Address changes are refused while a write runs.
		if (io_wr && io_addr == OFS_ADDR_HIGH && !busy_ff)                  // see RULE_15
			nxt_rom_addr[8] = io_wdata[0];                                  // see RULE_02
		if (io_wr && io_addr == OFS_ADDR_LOW && !busy_ff)
			nxt_rom_addr[7:0] = io_wdata;
		if (io_wr && io_addr == OFS_DATA)
			nxt_rom_data = io_wdata;
		// Fetched byte lands in the data register one cycle after the array read.
		if (cap_ff)
			nxt_rom_data = mem_rdata;                                       // see RULE_04 see RULE_13
		// Arm window: held four cycles after software sets it, then cleared.
		if (arm_cnt_ff != 3'h0)
		begin
			nxt_arm_cnt = arm_cnt_ff - 3'h1;
			if (arm_cnt_ff == 3'h1)
				nxt_arm = 1'b0;                                             // see RULE_07
		end
		if (wr_ctrl)
		begin
			nxt_ready_ie = io_wdata[BIT_READY_IE];                          // see RULE_05
			if (io_wdata[BIT_ARM])
			begin
				nxt_arm     = 1'b1;
				nxt_arm_cnt = 3'(ARM_CYCLES);
			end
		end
		// Write timer counts the oscillator-derived write time, then drops the strobe.
		// The countdown also runs while resetn is low; only the power reset stops it.
		if (start_write)
		begin
			nxt_busy = 1'b1;                                                // see RULE_11
			nxt_wcnt = 20'(WRITE_TIME_CLKS - 1);                            // see RULE_16
			nxt_stall = 3'(WRITE_STALL);                                    // see RULE_12
		end
		else if (busy_ff)
		begin
			if (wcnt_ff == 20'h00000)
				nxt_busy = 1'b0;                                            // see RULE_11
			else
				nxt_wcnt = wcnt_ff - 20'h00001;
		end
		if (start_read)
			nxt_stall = 3'(READ_STALL);                                     // see RULE_14
		// Read mux; reserved bits read zero.
		unique case (io_addr)
			OFS_ADDR_HIGH: nxt_rdata = {7'h00, rom_addr_ff[8]};            // see RULE_01
			OFS_ADDR_LOW:  nxt_rdata = rom_addr_ff[7:0];
			OFS_DATA:      nxt_rdata = rom_data_ff;
			OFS_CONTROL:   nxt_rdata = {4'h0, ready_ie_ff, arm_ff, busy_ff, re_ff | cap_ff}; // see RULE_01
		endcase
		if (!io_rd)
			nxt_rdata = rdata_ff;
	end

	// Register update; a running write outlives a plain reset, only power reset kills it.
	always_ff @(posedge clk)
	begin
		if (!resetn || !pwr_resetn)
		begin
			rom_addr_ff <= ADDR_RESET;
			rom_data_ff <= DATA_RESET;
			rdata_ff    <= 8'h00;
			ready_ie_ff <= 1'b0;
			arm_ff      <= 1'b0;
			arm_cnt_ff  <= 3'h0;
			we_ff       <= 1'b0;
			re_ff       <= 1'b0;
			cap_ff      <= 1'b0;
			stall_ff    <= 3'h0;
		end
		else
		begin
			rom_addr_ff <= nxt_rom_addr;
			rom_data_ff <= nxt_rom_data;
			rdata_ff    <= nxt_rdata;
			ready_ie_ff <= nxt_ready_ie;
			arm_ff      <= nxt_arm;
			arm_cnt_ff  <= nxt_arm_cnt;
			we_ff       <= nxt_we;
			re_ff       <= nxt_re;
			cap_ff      <= nxt_cap;
			stall_ff    <= nxt_stall;
		end
	end

	// Write timer only sees the power reset, so a plain reset lets a running write finish.
	// Its next values come from the shared next-state process above.
	always_ff @(posedge clk)
	begin
		if (!pwr_resetn)
		begin
			busy_ff <= 1'b0;
			wcnt_ff <= 20'h00000;
		end
		else
		begin
			busy_ff <= nxt_busy;                                            // see RULE_17
			wcnt_ff <= nxt_wcnt;
		end
	end

	// Outputs.
	assign io_rdata      = rdata_ff;
	assign mem_addr      = rom_addr_ff;
	assign mem_wdata     = rom_data_ff;
	assign mem_we        = we_ff;
	assign mem_re        = re_ff;
	assign cpu_stall     = stall_ff != 3'h0;
	assign rom_ready_irq = ready_ie_ff && core_irq_enable && !busy_ff;    // see RULE_05

	// Checks.
	a_arm_timeout: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_07
		wr_ctrl && io_wdata[BIT_ARM] ##1 (!(wr_ctrl && io_wdata[BIT_ARM])) [*4] |-> arm_ff ##1 !arm_ff)
		else $error("arm bit did not clear after four cycles");
	a_write_gated: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_06
		mem_we |-> $past(arm_ff) && !$past(busy_ff))
		else $error("write started without arm or during busy");
	a_write_stall: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_12
		start_write |=> cpu_stall [*2] ##1 !cpu_stall)
		else $error("write stall not two cycles");
	a_read_stall: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_14
		start_read |=> cpu_stall [*4] ##1 !cpu_stall)
		else $error("read stall not four cycles");
	a_read_data: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_13
		mem_re |=> ##1 rom_data_ff == $past(mem_rdata))
		else $error("read byte not captured");
	a_addr_frozen: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_15
		busy_ff && $past(busy_ff) && $past(resetn) |-> $stable(rom_addr_ff))
		else $error("address changed during write");
	a_no_read_busy: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_15
		busy_ff |-> !start_read)
		else $error("read accepted during write");
	a_irq_level: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_05
		rom_ready_irq == (ready_ie_ff && core_irq_enable && !busy_ff))
		else $error("ready interrupt level wrong");
	a_no_flash_clash: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_09
		self_program_active |=> !$rose(busy_ff))
		else $error("write began during flash programming");
	a_strobe_held: assert property (@(posedge clk) disable iff (!pwr_resetn) // see RULE_11
		$rose(busy_ff) |-> busy_ff [*8])
		else $error("write strobe dropped early");
	a_ctrl_reserved: assert property (@(posedge clk) disable iff (!resetn || !pwr_resetn) // see RULE_01
		$past(io_rd) && $past(io_addr) == OFS_CONTROL |-> io_rdata[7:4] == 4'h0)
		else $error("reserved control bits not zero");
endmodule

// file: verification/tb.sv
// Self-checking testbench for the data EEPROM access controller.
`timescale 1ns/1ps
module tb
	import eac_pkg::*;
;
	// Design connections and bench bookkeeping.
	logic		clk, resetn, pwr_resetn, io_wr, io_rd, core_irq_enable, self_program_active;
	logic		cpu_stall, rom_ready_irq, mem_we, mem_re;
	logic [1:0]	io_addr;
	logic [7:0]	io_wdata, io_rdata, mem_wdata, mem_rdata, r;
	logic [8:0]	mem_addr;
	int		error_cnt = 0;
	int		n_compared = 0;
	int		cyc = 0;
	int		t0, n;

	eac_ctrl #(.WRITE_TIME_CLKS(60)) u_eac_ctrl (.clk(clk), .resetn(resetn), .pwr_resetn(pwr_resetn),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.core_irq_enable(core_irq_enable), .self_program_active(self_program_active), .cpu_stall(cpu_stall),
		.rom_ready_irq(rom_ready_irq), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.mem_re(mem_re), .mem_rdata(mem_rdata));

	// Cell array stand-in: each byte is a fixed function of its address.
	assign mem_rdata = mem_addr[7:0] ^ 8'h5A;

	// Free-running clock of 10 ns and an edge counter for timing checks.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	// Compares one result and records the outcome.
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Register write: request held for one cycle, taken at the following edge.
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask

	// Register read: the answer is registered at the taking edge.
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		#1;
		d = io_rdata;
	endtask

	task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
		rd(a, r);
		chk(9'(r), 9'(exp));
	endtask

	// Counts the cycles the core is held, starting from a settled point.
	task automatic stall_len(output int k);
		k = 0;
		while (cpu_stall === 1'b1 && k < 20)
		begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask

	task automatic results;
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog: the whole sequence needs about 150 cycles, so 2000 means a hang.
	initial
	begin
		#20000;
		error_cnt++;
		results();
	end

	// Main sequence of register accesses.
	initial
	begin
		{resetn, pwr_resetn, io_wr, io_rd, core_irq_enable, self_program_active} = 6'h00;
		io_addr = 2'h0;
		io_wdata = 8'h00;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		pwr_resetn <= 1'b1;
		rdc(OFS_CONTROL, 8'h00);
		wr(OFS_ADDR_HIGH, 8'hFF);
		wr(OFS_ADDR_LOW, 8'h34);
		rdc(OFS_ADDR_HIGH, 8'h01);
		wr(OFS_DATA, 8'hA5);
		rdc(OFS_DATA, 8'hA5);
		wr(OFS_CONTROL, 8'hF8);
		rdc(OFS_CONTROL, 8'h08);
		wr(OFS_CONTROL, 8'h01);
		#1 chk(9'(mem_re), 9'h001);
		chk(mem_addr, 9'h134);
		stall_len(n);
		chk(9'(n), 9'h004);
		rdc(OFS_DATA, 8'h6E);
		wr(OFS_CONTROL, 8'h02);
		#1 chk(9'(mem_we), 9'h000);
		wr(OFS_CONTROL, 8'h04);
		rdc(OFS_CONTROL, 8'h04);
		repeat (4) @(posedge clk);
		wr(OFS_CONTROL, 8'h02);
		#1 chk(9'(mem_we), 9'h000);
		@(posedge clk) self_program_active <= 1'b1;
		wr(OFS_CONTROL, 8'h04);
		wr(OFS_CONTROL, 8'h02);
		#1 chk(9'(mem_we), 9'h000);
		@(posedge clk) self_program_active <= 1'b0;
		core_irq_enable <= 1'b1;
		wr(OFS_CONTROL, 8'h08);
		#1 chk(9'(rom_ready_irq), 9'h001);
		wr(OFS_DATA, 8'hC3);
		wr(OFS_CONTROL, 8'h0C);
		wr(OFS_CONTROL, 8'h0A);
		#1 chk(9'(mem_we), 9'h001);
		t0 = cyc;
		chk(9'(mem_wdata), 9'h0C3);
		chk(mem_addr, 9'h134);
		chk(9'(rom_ready_irq), 9'h000);
		stall_len(n);
		chk(9'(n), 9'h002);
		rdc(OFS_CONTROL, 8'h0A);
		wr(OFS_ADDR_LOW, 8'h77);
		rdc(OFS_ADDR_LOW, 8'h34);
		wr(OFS_CONTROL, 8'h09);
		#1 chk(9'(mem_re), 9'h000);
		wr(OFS_CONTROL, 8'h0C);
		wr(OFS_CONTROL, 8'h0A);
		#1 chk(9'(mem_we), 9'h000);
		@(posedge clk) resetn <= 1'b0;
		@(posedge clk) resetn <= 1'b1;
		rdc(OFS_CONTROL, 8'h02);
		n = 0;
		while (r[1] !== 1'b0 && n < 100)
		begin
			rd(OFS_CONTROL, r);
			n++;
		end
		chk(9'(cyc - t0 >= 60 && cyc - t0 <= 63), 9'h001);
		wr(OFS_CONTROL, 8'h08);
		#1 chk(9'(rom_ready_irq), 9'h001);
		@(posedge clk) core_irq_enable <= 1'b0;
		#1 chk(9'(rom_ready_irq), 9'h000);
		wr(OFS_ADDR_LOW, 8'h10);
		wr(OFS_CONTROL, 8'h04);
		wr(OFS_CONTROL, 8'h02);
		#1 chk(9'(mem_we), 9'h001);
		chk(mem_addr, 9'h010);
		@(posedge clk) pwr_resetn <= 1'b0;
		@(posedge clk) pwr_resetn <= 1'b1;
		rdc(OFS_CONTROL, 8'h00);
		results();
	end
endmodule
